// file: design/tgsp_gate_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - Single pulse gating applies only while the single-pulse enable is set
// - Once armed, counting opens at the next incrementing gate edge
// - Trailing gate edge clears arm/done, marking the pulse captured
// - With arm/done clear in single pulse mode, gate events do not count
// - Clearing single-pulse enable also clears arm/done
// - Toggle plus single pulse together count one full gate source cycle
// - Gate level status shows the most recent gate control level
// - Gate level status stays live even with gate count enable clear
module tgsp_gate_ctrl
    import tgsp_pkg::*;
(
    input  wire logic                              ref_clk,
    input  wire logic                              rst,
    input  wire logic                              gate_src,
    input  wire logic                              gate_invert,
    input  wire logic                              timer_on,
    input  wire logic                              gate_count_enable,
    input  wire logic                              gate_toggle_enable,
    input  wire logic                              gate_single_pulse_enable,
    input  wire logic                              gate_arm_set,
    input  wire logic                              count_clear,
    output logic                                   gate_arm_done,
    output logic                                   gate_level_status,
    output logic                                   count_active,
    output logic [tgsp_pkg::TGSP_CNT_W-1:0]        count_value
);
    import tgsp_pkg::*;

    // All block state in one packed register, filled by one comb process;
    // keeping it together makes the reset values easy to audit
    typedef struct packed {
        tgsp_state_e            sp;
        logic                   arm;
        logic                   tog;
        logic                   src_prev;
        logic                   gval;
        logic                   gval_prev;
        logic [TGSP_CNT_W-1:0]  cnt;
    } tgsp_ctrl_s;

    // Present and next copies of the state
    tgsp_ctrl_s st_ff;
    tgsp_ctrl_s nxt_st;

    // Cleaned gate level; the synchroniser owns its only driver
    tgsp_gate_if gate_bus ();

    // Pin crosses four flops here; all later logic sees a settled level,
    // at the price of a few cycles between pin and status
    tgsp_gate_sync u_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .gate_src (gate_src),
        .gate     (gate_bus)
    );

    // Leading edge of a level against its copy from one clock earlier
    function automatic logic rise_of(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction

    // Trailing edge of a level against its copy from one clock earlier
    function automatic logic fall_of(input logic cur, input logic prev);
        return ~cur & prev;
    endfunction

    // Counter step; clear wins over counting so software reads a clean zero.
    // The counter wraps silently, there is no overflow flag in this block.
    function automatic logic [TGSP_CNT_W-1:0] next_count(
        input logic                  clr,
        input logic                  run,
        input logic [TGSP_CNT_W-1:0] cur
    );
        if (clr) begin
            return TGSP_CNT_RST;
        end else if (run) begin
            return cur + TGSP_CNT_ONE;
        end
        return cur;
    endfunction

    // Source level in active sense and its incrementing edge. The polarity
    // select sits behind the synchroniser, so flipping it mid-run reads as an
    // edge; change it only while the gate is not in use.
    logic src_act;
    logic src_rise;

    // Internal gate value before its register, and its two edges;
    // the edges feed the single pulse sequencer only
    logic gval_now;
    logic g_rise;
    logic g_fall;

    // Counting window for this cycle
    logic gate_open;

    // Active-sense source, then its incrementing edge
    assign src_act  = gate_bus.gate_level ^ gate_invert;
    assign src_rise = rise_of(src_act, st_ff.src_prev);

    // Gate value before the register; toggle form flips on each source rise,
    // so one internal pulse spans a whole source period and single pulse
    // mode can measure a full cycle
    always_comb begin
        if (gate_toggle_enable) begin
            gval_now = st_ff.tog ^ src_rise;
        end else begin
            gval_now = src_act;
        end
    end

    // Edges come from registered values, so each lasts exactly one cycle
    assign g_rise = rise_of(st_ff.gval, st_ff.gval_prev);
    assign g_fall = fall_of(st_ff.gval, st_ff.gval_prev);

    // Counting window. With gate counting off the timer runs freely; with
    // single pulse on it opens only for the one captured pulse, so a pulse
    // that comes while unarmed or already done is not counted
    always_comb begin
        if (!gate_count_enable) begin
            gate_open = 1'b1;
        end else if (gate_single_pulse_enable) begin
            gate_open = (st_ff.sp == TGSP_OPEN) & st_ff.gval;
        end else begin
            gate_open = st_ff.gval;
        end
    end

    // Next state: gate tracking first, then the sequencer, then the counter.
    // Everything is computed from the registered state, so a software write
    // and a gate edge in the same cycle resolve in one place.
    always_comb begin
        nxt_st           = st_ff;
        nxt_st.src_prev  = src_act;
        nxt_st.gval      = gval_now;
        nxt_st.gval_prev = st_ff.gval;

        // Toggle held low when off so enabling it starts from a known phase;
        // the first source rise after enabling then opens the gate
        if (gate_toggle_enable) begin
            nxt_st.tog = gval_now;
        end else begin
            nxt_st.tog = TGSP_TOG_RST;
        end

        // Single pulse sequencer: IDLE waits for software to arm, ARMED waits
        // for the incrementing gate edge, OPEN counts until the trailing edge.
        // Dropping the mode enable forces IDLE and clears arm at once.
        if (!gate_single_pulse_enable) begin
            nxt_st.sp  = TGSP_IDLE;
            nxt_st.arm = 1'b0;
        end else begin
            case (st_ff.sp)
                TGSP_IDLE: begin
                    // Arm only once the mode is on; an earlier set is dropped
                    if (gate_arm_set) begin
                        nxt_st.arm = 1'b1;
                        nxt_st.sp  = TGSP_ARMED;
                    end
                end

                TGSP_ARMED: begin
                    // Already armed, so a repeated set changes nothing;
                    // a gate already high must fall and rise again first
                    if (g_rise) begin
                        nxt_st.sp = TGSP_OPEN;
                    end
                end

                TGSP_OPEN: begin
                    // A set landing on the trailing edge wins and re-arms;
                    // a set while the pulse is still open just keeps arm high
                    if (gate_arm_set) begin
                        nxt_st.arm = 1'b1;
                        if (g_fall) begin
                            nxt_st.sp = TGSP_ARMED;
                        end else begin
                            nxt_st.sp = TGSP_OPEN;
                        end
                    end else if (g_fall) begin
                        nxt_st.arm = 1'b0;
                        nxt_st.sp  = TGSP_IDLE;
                    end
                end

                default: begin
                    // Unused code falls back to a safe idle
                    nxt_st.sp = TGSP_IDLE;
                end
            endcase
        end

        // Counter runs only while the timer is on and the window is open
        nxt_st.cnt = next_count(count_clear, timer_on && gate_open, st_ff.cnt);
    end

    // State register; every field resets to its package value, so with gate counting on
    // and no inversion the gate reads low and nothing counts until the pin has settled
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff.sp        <= TGSP_IDLE;
            st_ff.arm       <= TGSP_ARM_RST;
            st_ff.tog       <= TGSP_TOG_RST;
            st_ff.src_prev  <= TGSP_LVL_RST;
            st_ff.gval      <= TGSP_LVL_RST;
            st_ff.gval_prev <= TGSP_LVL_RST;
            st_ff.cnt       <= TGSP_CNT_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Flag, level and count straight from flops; the count qualifier is
    // combinational so it matches the cycle in which the counter steps
    assign gate_arm_done     = st_ff.arm;
    assign gate_level_status = st_ff.gval;
    assign count_active      = timer_on & gate_open;
    assign count_value       = st_ff.cnt;
endmodule // tgsp_gate_ctrl

// file: design/tgsp_pkg.sv
package tgsp_pkg;
    // Counter geometry and reset values
    localparam int          TGSP_CNT_W       = 16;
    localparam logic [15:0] TGSP_CNT_RST     = 16'h0000;
    localparam logic        TGSP_ARM_RST     = 1'b0;
    localparam logic        TGSP_LVL_RST     = 1'b0;
    localparam logic        TGSP_TOG_RST     = 1'b0;
    localparam logic [15:0] TGSP_CNT_ONE     = 16'h0001;

    // Single pulse sequencer
    typedef enum logic [1:0] {
        TGSP_IDLE,
        TGSP_ARMED,
        TGSP_OPEN
    } tgsp_state_e;
endpackage

// file: design/tgsp_gate_if.sv
`timescale 1ns/1ps
// Carries the cleaned gate level from the synchroniser to the control logic
interface tgsp_gate_if;
    logic gate_level;
    modport sync (output gate_level);
    modport ctrl (input  gate_level);
endinterface

// file: design/tgsp_gate_sync.sv
`timescale 1ns/1ps
module tgsp_gate_sync
    import tgsp_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic gate_src,
    tgsp_gate_if.sync gate
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } tgsp_sync_s;

    tgsp_sync_s st_ff;
    tgsp_sync_s nxt_st;

    // Level moves only once stages two and three agree, filtering metastable settling
    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = gate_src;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        if (st_ff.s2 == st_ff.s3) begin
            nxt_st.lvl = st_ff.s3;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign gate.gate_level = st_ff.lvl;
endmodule // tgsp_gate_sync

// file: tb/tgsp_src_model.sv
`timescale 1ns/1ps
// Gate source pin; rests low between pulses like a quiet source
module tgsp_src_model (
    input  wire logic ref_clk,
    output logic      gate_src
);
    initial gate_src = 1'b0;
    // Level changes just after an edge, then holds for n cycles
    task automatic hold(input logic v, input int n);
        gate_src <= v;
        repeat (n) @(posedge ref_clk);
    endtask
endmodule // tgsp_src_model

// file: tb/tgsp_gate_ctrl_assertions.sv
`timescale 1ns/1ps
module tgsp_chk (
    input wire logic ref_clk, rst, gate_src, gate_invert, timer_on, gate_count_enable, gate_toggle_enable,
    input wire logic gate_single_pulse_enable, gate_arm_set, count_clear, gate_arm_done, gate_level_status,
    input wire logic count_active,
    input wire logic [tgsp_pkg::TGSP_CNT_W-1:0] count_value
);
    import tgsp_pkg::*;
    // One domain, so clock and reset are declared once
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_arm_needs_spm: assert property ($rose(gate_arm_done) |-> $past(gate_arm_set && gate_single_pulse_enable))
        else $error("arm without enable");
    a_open_after_rise: assert property ($rose(gate_level_status) && gate_arm_done && gate_single_pulse_enable
        && gate_count_enable && timer_on |-> ##[1:2] count_active) else $error("gate did not open");
    a_done_on_trail: assert property ($fell(gate_arm_done)
        |-> $past(!gate_single_pulse_enable || !gate_level_status)) else $error("early done");
    a_no_count_unarmed: assert property (gate_single_pulse_enable && gate_count_enable && !gate_arm_done
        |-> !count_active) else $error("count while unarmed");
    a_spm_off_clears: assert property (!gate_single_pulse_enable |=> !gate_arm_done) else $error("arm kept");
    a_level_follows: assert property ((!gate_toggle_enable && $changed(gate_src)) ##1 $stable(gate_src)[*6]
        |-> gate_level_status == (gate_src ^ gate_invert)) else $error("status stale");
    a_toggle_holds: assert property ((gate_toggle_enable && $stable(gate_src))[*8]
        |=> $stable(gate_level_status)) else $error("toggle without edge");
    a_count_step: assert property (count_active && !count_clear
        |=> count_value == $past(count_value) + TGSP_CNT_ONE) else $error("count step");
endmodule // tgsp_chk
bind tgsp_gate_ctrl tgsp_chk u_chk (.*);

// file: tb/tgsp_gate_ctrl_tb_top.sv
`timescale 1ns/1ps
module tgsp_gate_ctrl_tb_top;
    import tgsp_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, gate_src, gate_invert = 1'b0, timer_on = 1'b0, gate_count_enable = 1'b0;
    logic gate_toggle_enable = 1'b0, gate_single_pulse_enable = 1'b0, gate_arm_set = 1'b0, count_clear = 1'b0;
    logic gate_arm_done, gate_level_status, count_active;
    logic [TGSP_CNT_W-1:0] count_value;
    int miscompares = 0, compares = 0;
    tgsp_gate_ctrl dut (.*);
    tgsp_src_model src (.ref_clk(ref_clk), .gate_src(gate_src));
    // 100 MHz
    initial forever #5 ref_clk = ~ref_clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Range compare; case equality so an unknown never passes
    task automatic chk(input string n, input logic [15:0] lo, hi, got);
        compares++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            miscompares++;
            $display("unexpected %s: expected %0h..%0h, seen %0h", n, lo, hi, got);
        end
    endtask
    task automatic arm;
        gate_arm_set <= 1'b1;
        cyc(1);
        gate_arm_set <= 1'b0;
        cyc(1);
    endtask
    task automatic give_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Status follows the pin with gating off, inversion too
    task automatic t_level;
        src.hold(1'b1, 8);
        chk("level", 1, 1, gate_level_status);
        src.hold(1'b0, 8);
        chk("level", 0, 0, gate_level_status);
        gate_invert <= 1'b1;
        cyc(8);
        chk("level inv", 1, 1, gate_level_status);
        gate_invert <= 1'b0;
        cyc(8);
    endtask
    // One pulse captured, later pulses ignored, disable drops arm
    task automatic t_single;
        gate_count_enable <= 1'b1;
        timer_on <= 1'b1;
        arm;
        chk("arm refused", 0, 0, gate_arm_done);
        gate_single_pulse_enable <= 1'b1;
        count_clear <= 1'b1;
        cyc(1);
        count_clear <= 1'b0;
        arm;
        chk("armed", 1, 1, gate_arm_done);
        src.hold(1'b0, 4);
        chk("count armed", 0, 0, count_value);
        chk("active armed", 0, 0, count_active);
        src.hold(1'b1, 10);
        chk("active open", 1, 1, count_active);
        cyc(10);
        src.hold(1'b0, 10);
        chk("done", 0, 0, gate_arm_done);
        chk("count", 18, 22, count_value);
        src.hold(1'b1, 20);
        src.hold(1'b0, 10);
        chk("count held", 18, 22, count_value);
        chk("active done", 0, 0, count_active);
        arm;
        gate_single_pulse_enable <= 1'b0;
        cyc(2);
        chk("spm off", 0, 0, gate_arm_done);
    endtask
    // Toggle plus single pulse spans one source period
    task automatic t_toggle;
        gate_toggle_enable <= 1'b1;
        gate_single_pulse_enable <= 1'b1;
        count_clear <= 1'b1;
        cyc(1);
        count_clear <= 1'b0;
        arm;
        repeat (3) begin
            src.hold(1'b1, 10);
            src.hold(1'b0, 10);
        end
        chk("period count", 18, 22, count_value);
        chk("done", 0, 0, gate_arm_done);
    endtask
    // Main sequence after a five-cycle reset
    initial begin
        cyc(5);
        rst <= 1'b0;
        cyc(2);
        t_level;
        t_single;
        t_toggle;
        give_verdict;
    end
    // Watchdog, well past the roughly 175 cycles needed
    initial begin
        #20us;
        miscompares++;
        give_verdict;
    end
endmodule // tgsp_gate_ctrl_tb_top
